/* core/esw_pkg.sv */
package esw_pkg;

	// array geometry
	localparam int ESW_ADDR_W = 9;
	localparam int ESW_BYTE_W = 8;

	// instruction bytes, shifted msb first
	localparam logic [7:0] ESW_OP_LATCH_SET = 8'h06;
	localparam logic [7:0] ESW_OP_LATCH_CLR = 8'h04;
	localparam logic [7:0] ESW_OP_STAT_RD = 8'h05;
	localparam logic [7:0] ESW_OP_STAT_WR = 8'h01;
	localparam logic [7:0] ESW_OP_ARRAY_WR = 8'h02;
	localparam logic [7:0] ESW_OP_ARRAY_WR_MASK = 8'hf7;
	localparam int ESW_OP_A8_POS = 3;

	// status byte layout
	localparam int ESW_ST_BUSY = 0;
	localparam int ESW_ST_LATCH = 1;
	localparam int ESW_ST_GUARD_LO = 2;
	localparam int ESW_ST_GUARD_HI = 3;
	localparam logic [3:0] ESW_ST_UNDEF = 4'h0;

	// block-guard codes and protected region bases
	localparam logic [1:0] ESW_GUARD_NONE = 2'h0;
	localparam logic [1:0] ESW_GUARD_QUARTER = 2'h1;
	localparam logic [1:0] ESW_GUARD_HALF = 2'h2;
	localparam logic [1:0] ESW_GUARD_ALL = 2'h3;
	localparam logic [ESW_ADDR_W-1:0] ESW_QUARTER_BASE = 9'h180;
	localparam logic [ESW_ADDR_W-1:0] ESW_HALF_BASE = 9'h100;

	// frame length checks, in whole bytes, and bit positions within a byte
	localparam logic [2:0] ESW_BYTES_CMD = 3'h1;
	localparam logic [2:0] ESW_BYTES_STAT_WR = 3'h2;
	localparam logic [2:0] ESW_BYTES_ARRAY_MIN = 3'h3;
	localparam logic [2:0] ESW_BYTES_SAT = 3'h7;
	localparam logic [2:0] ESW_BIT_LAST = 3'h7;
	localparam logic [2:0] ESW_BIT_FIRST = 3'h1;

	// reset levels
	localparam logic [1:0] ESW_GUARD_RST = 2'h0;
	localparam logic [ESW_ADDR_W-1:0] ESW_ADDR_RST = 9'h000;

	function automatic logic esw_guarded(input logic [1:0] guard,
		input logic [ESW_ADDR_W-1:0] addr);
		logic hit;
		hit = 1'b0;
		case (guard)
			ESW_GUARD_NONE: hit = 1'b0;
			ESW_GUARD_QUARTER: hit = (addr >= ESW_QUARTER_BASE);
			ESW_GUARD_HALF: hit = (addr >= ESW_HALF_BASE);
			ESW_GUARD_ALL: hit = 1'b1;
			default: hit = 1'b1;
		endcase
		return hit;
	endfunction

endpackage

/* core/esw_status_protect.sv */
// Functional notes
// - status read answered anytime, even while busy
// - bit 0 busy flag; bits 7..4 undefined
// - bit 1 latch; latch low refuses writes
// - latch commands work regardless of guard bits
// - busy and latch not writable by status write
// - guard bits change only by status write
// - guard decode: none, quarter, half, all
// - latch cleared at power-up, set explicitly
// - latch cleared after array or status write
// - write starts only on byte-boundary deselect
// - array writes ignored while busy
// - guard pin low holds latch cleared
// - power-on deselected, output released, latch clear
// - guard pin low refuses all writes
// - latch set and clear instruction codes
// - status read and write instruction codes
// - latch set only on deselect after eight bits
module esw_status_protect
	import esw_pkg::*;
#(
	parameter int ADDR_W = ESW_ADDR_W
) (
	input wire logic i_sys_clk, // system clock, 20 MHz
	input wire logic i_nrst, // async reset, active low
	input wire logic i_sck, // serial clock from master
	input wire logic i_cs_n, // chip select, active low
	input wire logic i_si, // serial data in
	output logic o_so, // serial data out
	output logic o_so_oe, // serial out enable
	input wire logic i_write_guard_n, // write guard pin, low protects
	input wire logic [1:0] i_guard_nv, // stored guard bits at power-up
	input wire logic i_prog_done, // programming finished pulse
	output logic o_write_start, // programming start pulse
	output logic o_write_status, // start targets the guard bits
	output logic [ADDR_W-1:0] o_write_addr, // first array address
	output logic [1:0] o_guard_bits, // guard bits to store
	output logic o_array_ready, // array access allowed
	output logic [7:0] o_status // live status byte
);

	if (ADDR_W != ESW_ADDR_W) begin : g_chk
		$error("esw_status_protect: ADDR_W must match the array size");
	end

	// ---------------- serial clock domain ----------------
	logic new_frame_reg;
	logic frame_tog_reg;
	logic [2:0] bit_cnt_reg;
	logic [2:0] byte_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] opcode_reg;
	logic [7:0] data_reg;
	logic [3:0] stat_meta_reg;
	logic [3:0] stat_sync_reg;
	logic so_reg;
	logic so_oe_reg;
	logic [7:0] rx_byte;
	logic [7:0] stat_byte_sck;
	logic rd_active;

	// system-domain state, declared here for the crossings
	logic busy_reg;
	logic latch_reg;
	logic [1:0] guard_reg;

	assign rx_byte = {shift_reg[6:0], i_si};

	// set asynchronously while deselected, so the next frame starts clean
	always_ff @(posedge i_sck or posedge i_cs_n or negedge i_nrst) begin
		if (!i_nrst) begin
			new_frame_reg <= 1'b1;
		end else if (i_cs_n) begin
			new_frame_reg <= 1'b1;
		end else begin
			new_frame_reg <= 1'b0;
		end
	end

	// one toggle per clocked frame, tells the system side a frame happened
	always_ff @(posedge i_sck or negedge i_nrst) begin
		if (!i_nrst) begin
			frame_tog_reg <= 1'b0;
		end else if (new_frame_reg) begin
			frame_tog_reg <= ~frame_tog_reg;
		end
	end

	// msb-first receive, bit and byte position within the frame
	always_ff @(posedge i_sck or negedge i_nrst) begin
		if (!i_nrst) begin
			shift_reg <= 8'h00;
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 3'h0;
		end else if (new_frame_reg) begin
			shift_reg <= {7'h00, i_si};
			bit_cnt_reg <= ESW_BIT_FIRST;
			byte_cnt_reg <= 3'h0;
		end else begin
			shift_reg <= rx_byte;
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == ESW_BIT_LAST && byte_cnt_reg != ESW_BYTES_SAT) begin
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
			end
		end
	end

	// instruction byte and second byte (status value or low address)
	always_ff @(posedge i_sck or negedge i_nrst) begin
		if (!i_nrst) begin
			opcode_reg <= 8'h00;
			data_reg <= 8'h00;
		end else if (!new_frame_reg && bit_cnt_reg == ESW_BIT_LAST) begin
			if (byte_cnt_reg == 3'h0) begin
				opcode_reg <= rx_byte;
			end
			if (byte_cnt_reg == ESW_BYTES_CMD) begin
				data_reg <= rx_byte;
			end
		end
	end

	// status flags into the serial domain, two flops per independent bit
	always_ff @(posedge i_sck or negedge i_nrst) begin
		if (!i_nrst) begin
			stat_meta_reg <= 4'h0;
			stat_sync_reg <= 4'h0;
		end else begin
			stat_meta_reg <= {guard_reg, latch_reg, busy_reg};
			stat_sync_reg <= stat_meta_reg;
		end
	end

	assign stat_byte_sck = {ESW_ST_UNDEF, stat_sync_reg};
	assign rd_active = (opcode_reg == ESW_OP_STAT_RD) && (byte_cnt_reg != 3'h0);

	// status shifted out after falling edges, repeated while clocked; no busy gate
	always_ff @(negedge i_sck or posedge i_cs_n or negedge i_nrst) begin
		if (!i_nrst) begin
			so_reg <= 1'b1;
			so_oe_reg <= 1'b0;
		end else if (i_cs_n) begin
			so_reg <= 1'b1;
			so_oe_reg <= 1'b0;
		end else if (rd_active) begin
			so_reg <= stat_byte_sck[ESW_BIT_LAST - bit_cnt_reg];
			so_oe_reg <= 1'b1;
		end else begin
			so_reg <= 1'b1;
			so_oe_reg <= 1'b0;
		end
	end

	assign o_so = so_reg;
	assign o_so_oe = so_oe_reg;

	// ---------------- system clock domain ----------------
	logic cs_meta_reg;
	logic cs_sync_reg;
	logic cs_prev_reg;
	logic guard_meta_reg;
	logic guard_sync_reg;
	logic tog_meta_reg;
	logic tog_sync_reg;
	logic tog_seen_reg;
	logic loaded_reg;
	logic start_reg;
	logic start_stat_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic frame_end;
	logic frame_valid;
	logic on_boundary;
	logic is_latch_set;
	logic is_latch_clr;
	logic is_stat_wr;
	logic is_array_wr;
	logic write_ok;
	logic stat_wr_go;
	logic array_wr_go;
	logic [ADDR_W-1:0] frame_addr;

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
		end else begin
			cs_meta_reg <= i_cs_n;
			cs_sync_reg <= cs_meta_reg;
			cs_prev_reg <= cs_sync_reg;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			guard_meta_reg <= 1'b0;
			guard_sync_reg <= 1'b0;
		end else begin
			guard_meta_reg <= i_write_guard_n;
			guard_sync_reg <= guard_meta_reg;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tog_meta_reg <= 1'b0;
			tog_sync_reg <= 1'b0;
			tog_seen_reg <= 1'b0;
		end else begin
			tog_meta_reg <= frame_tog_reg;
			tog_sync_reg <= tog_meta_reg;
			if (frame_end) begin
				tog_seen_reg <= tog_sync_reg;
			end
		end
	end

	// frame words are static once deselected; read them at the synced rise
	assign frame_end = cs_sync_reg && !cs_prev_reg;
	assign frame_valid = frame_end && (tog_sync_reg != tog_seen_reg);
	assign on_boundary = (bit_cnt_reg == 3'h0);
	assign frame_addr = {opcode_reg[ESW_OP_A8_POS], data_reg};

	assign is_latch_set = (opcode_reg == ESW_OP_LATCH_SET)
		&& (byte_cnt_reg == ESW_BYTES_CMD) && on_boundary;
	assign is_latch_clr = (opcode_reg == ESW_OP_LATCH_CLR)
		&& (byte_cnt_reg == ESW_BYTES_CMD) && on_boundary;
	assign is_stat_wr = (opcode_reg == ESW_OP_STAT_WR)
		&& (byte_cnt_reg == ESW_BYTES_STAT_WR) && on_boundary;
	assign is_array_wr = ((opcode_reg & ESW_OP_ARRAY_WR_MASK) == ESW_OP_ARRAY_WR)
		&& (byte_cnt_reg >= ESW_BYTES_ARRAY_MIN) && on_boundary;

	assign write_ok = guard_sync_reg && latch_reg && !busy_reg;
	assign stat_wr_go = frame_valid && is_stat_wr && write_ok;
	assign array_wr_go = frame_valid && is_array_wr && write_ok
		&& !esw_guarded(guard_reg, frame_addr);

	// latch: pin low dominates, then set, then clears
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			latch_reg <= 1'b0;
		end else if (!guard_sync_reg) begin
			latch_reg <= 1'b0;
		end else if (frame_valid && is_latch_set) begin
			latch_reg <= 1'b1;
		end else if (frame_valid && is_latch_clr) begin
			latch_reg <= 1'b0;
		end else if (stat_wr_go || array_wr_go) begin
			latch_reg <= 1'b0;
		end
	end

	// busy: a new start wins over a finishing pulse in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_reg <= 1'b0;
		end else if (stat_wr_go || array_wr_go) begin
			busy_reg <= 1'b1;
		end else if (i_prog_done) begin
			busy_reg <= 1'b0;
		end
	end

	// guard bits: stored value taken once after reset release
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			loaded_reg <= 1'b0;
			guard_reg <= ESW_GUARD_RST;
		end else if (!loaded_reg) begin
			loaded_reg <= 1'b1;
			guard_reg <= i_guard_nv;
		end else if (stat_wr_go) begin
			guard_reg <= data_reg[ESW_ST_GUARD_HI:ESW_ST_GUARD_LO];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			start_reg <= 1'b0;
			start_stat_reg <= 1'b0;
			addr_reg <= ESW_ADDR_RST;
		end else begin
			start_reg <= stat_wr_go || array_wr_go;
			if (stat_wr_go || array_wr_go) begin
				start_stat_reg <= stat_wr_go;
			end
			if (array_wr_go) begin
				addr_reg <= frame_addr;
			end
		end
	end

	assign o_write_start = start_reg;
	assign o_write_status = start_stat_reg;
	assign o_write_addr = addr_reg;
	assign o_guard_bits = guard_reg;
	assign o_array_ready = !busy_reg;
	assign o_status = {ESW_ST_UNDEF, guard_reg, latch_reg, busy_reg};

	// ---------------- checks ----------------
	sequence s_start_req;
		frame_valid && (is_stat_wr || is_array_wr);
	endsequence

	sequence s_latch_req;
		frame_valid && is_latch_set && guard_sync_reg;
	endsequence

	a_guard_clears_latch: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		!guard_sync_reg |=> !latch_reg)
		else $error("latch set while guard pin low");

	a_start_sets_busy: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		o_write_start |-> busy_reg && o_status[ESW_ST_BUSY])
		else $error("busy not reported after write start");

	a_start_clears_latch: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		o_write_start |-> !latch_reg)
		else $error("latch still set after write start");

	a_latch_gates_start: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		s_start_req ##0 !latch_reg |=> !o_write_start)
		else $error("write started without latch");

	a_busy_blocks_start: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		busy_reg ##0 !o_write_start |=> !o_write_start)
		else $error("write started while busy");

	a_pin_blocks_start: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		!guard_sync_reg |=> !o_write_start)
		else $error("write started with guard pin low");

	a_guard_stable: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		loaded_reg && !stat_wr_go |=> $stable(guard_reg))
		else $error("guard bits changed without status write");

	a_protect_decode: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		o_write_start && !o_write_status |-> !esw_guarded(guard_reg, o_write_addr))
		else $error("write started into guarded region");

	a_latch_set_cause: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		$rose(latch_reg) |-> $past(frame_valid) && $past(is_latch_set))
		else $error("latch set without a latch set frame");

	a_latch_set_done: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		s_latch_req |=> latch_reg)
		else $error("latch set frame ignored");

	a_start_timing: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		o_write_start |-> $past(frame_end) && $past(on_boundary))
		else $error("write start not tied to a boundary deselect");

	a_oe_released: assert property (
		@(posedge i_sys_clk) disable iff (!i_nrst)
		cs_meta_reg && cs_sync_reg |-> !o_so_oe)
		else $error("serial out driven while deselected");

endmodule

/* bench/esw_spi_master.sv */
module esw_spi_master (
	output logic o_sck, // serial clock
	output logic o_cs_n, // chip select, active low
	output logic o_si, // serial data to device
	input wire logic i_so // serial data from device
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_si = 1'b1;
	end
	// n bits msb first; rx keeps the last eight bits seen on so
	task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rx);
		rx = 8'h00;
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_si = d[i];
			#80 o_sck = 1'b1;
			rx = {rx[6:0], i_so};
			#80 o_sck = 1'b0;
		end
		#80 o_cs_n = 1'b1;
		o_si = ~o_si;
		// deselect gap covers frame decode in the system domain
		#600;
	endtask
endmodule

/* bench/esw_status_protect_tb.sv */
module esw_status_protect_tb;
	import esw_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, sck, cs_n, si, so, so_oe, guard_n, prog_done;
	logic write_start, write_status, array_ready;
	logic [8:0] write_addr;
	logic [1:0] guard_bits;
	logic [1:0] guard_nv;
	logic [7:0] status;
	int errors = 0;
	int checked = 0;
	int starts = 0;
	// released line shows the inverse, so a missing enable corrupts the read
	wire so_line = so_oe ? so : ~so;

	esw_status_protect dut_u (
		.i_sys_clk(clk),
		.i_nrst(nrst),
		.i_sck(sck),
		.i_cs_n(cs_n),
		.i_si(si),
		.o_so(so),
		.o_so_oe(so_oe),
		.i_write_guard_n(guard_n),
		.i_guard_nv(guard_nv),
		.i_prog_done(prog_done),
		.o_write_start(write_start),
		.o_write_status(write_status),
		.o_write_addr(write_addr),
		.o_guard_bits(guard_bits),
		.o_array_ready(array_ready),
		.o_status(status)
	);

	esw_spi_master mst_u (
		.o_sck(sck),
		.o_cs_n(cs_n),
		.o_si(si),
		.i_so(so_line)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// mid-cycle sampling, away from the edge that launches the pulse
	always @(negedge clk) begin
		if (write_start === 1'b1) starts++;
	end

	task automatic results;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic frame(input logic [31:0] d, input int n);
		logic [7:0] rx;
		mst_u.xfer(d, n, rx);
	endtask

	task automatic latch_set;
		frame({24'h0, ESW_OP_LATCH_SET}, 8);
	endtask

	task automatic done_pulse;
		@(posedge clk);
		#5 prog_done = 1'b1;
		@(posedge clk);
		#5 prog_done = 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic set_guard(input logic [1:0] g);
		latch_set();
		frame({16'h0, ESW_OP_STAT_WR, 4'h0, g, 2'h0}, 16);
		done_pulse();
	endtask

	task automatic array_wr(input logic [8:0] a, input int n);
		// n = 24 sends the whole write; n = 25 adds one stray bit after it
		frame({7'h0, 4'h0, a[8], ESW_OP_ARRAY_WR[2:0], a[7:0], 8'h5a, 1'b1} >> (25 - n), n);
	endtask

	task automatic try_wr(input logic [8:0] a, input logic ok);
		int s;
		s = starts;
		latch_set();
		chk("latch", 9'h1, 9'(status[1]));
		array_wr(a, 24);
		chk("start", 9'(ok), 9'(starts - s));
		if (ok) begin
			chk("addr", a, write_addr);
			chk("wr_status", 9'h0, 9'(write_status));
			chk("latch", 9'h0, 9'(status[1]));
			done_pulse();
		end
	endtask

	task automatic t_reset;
		chk("status", 9'h000, 9'(status));
		chk("so_oe", 9'h0, 9'(so_oe));
		chk("ready", 9'h1, 9'(array_ready));
	endtask

	task automatic t_latch;
		latch_set();
		chk("status", 9'h002, 9'(status));
		frame({24'h0, ESW_OP_LATCH_CLR}, 8);
		chk("status", 9'h000, 9'(status));
		frame({16'h0, ESW_OP_LATCH_SET, 8'h00}, 16);
		chk("status", 9'h000, 9'(status));
	endtask

	task automatic t_status_wr;
		int s;
		logic [7:0] rx;
		s = starts;
		latch_set();
		frame({16'h0, ESW_OP_STAT_WR, 8'hfc}, 16);
		chk("status", 9'h00d, 9'(status));
		chk("start", 9'h1, 9'(starts - s));
		chk("wr_status", 9'h1, 9'(write_status));
		chk("guard", 9'h3, 9'(guard_bits));
		mst_u.xfer({16'h0, ESW_OP_STAT_RD, 8'h00}, 16, rx);
		chk("read", 9'h00d, 9'(rx));
		chk("ready", 9'h0, 9'(array_ready));
		done_pulse();
		chk("status", 9'h00c, 9'(status));
		frame({16'h0, ESW_OP_STAT_WR, 8'h00}, 16);
		chk("status", 9'h00c, 9'(status));
		chk("start", 9'h1, 9'(starts - s));
	endtask

	task automatic t_guard;
		set_guard(2'h1);
		try_wr(9'h17f, 1'b1);
		try_wr(9'h180, 1'b0);
		set_guard(2'h2);
		try_wr(9'h0ff, 1'b1);
		try_wr(9'h100, 1'b0);
		set_guard(2'h3);
		try_wr(9'h000, 1'b0);
		set_guard(2'h0);
		try_wr(9'h1ff, 1'b1);
	endtask

	task automatic t_abort_busy;
		int s;
		s = starts;
		latch_set();
		array_wr(9'h010, 25);
		chk("start", 9'h0, 9'(starts - s));
		chk("status", 9'h002, 9'(status));
		array_wr(9'h010, 24);
		latch_set();
		chk("status", 9'h003, 9'(status));
		array_wr(9'h020, 24);
		chk("start", 9'h1, 9'(starts - s));
		chk("addr", 9'h010, write_addr);
		done_pulse();
		chk("status", 9'h002, 9'(status));
	endtask

	task automatic t_pin;
		int s;
		s = starts;
		latch_set();
		@(posedge clk);
		#5 guard_n = 1'b0;
		repeat (6) @(posedge clk);
		chk("status", 9'h000, 9'(status));
		latch_set();
		chk("status", 9'h000, 9'(status));
		frame({16'h0, ESW_OP_STAT_WR, 8'h0c}, 16);
		chk("start", 9'h0, 9'(starts - s));
		chk("guard", 9'h0, 9'(guard_bits));
		@(posedge clk);
		#5 guard_n = 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic t_power;
		logic [7:0] rx;
		latch_set();
		chk("status", 9'h002, 9'(status));
		@(posedge clk);
		#5 nrst = 1'b0;
		guard_nv = 2'h2;
		repeat (4) @(posedge clk);
		#5 nrst = 1'b1;
		repeat (6) @(posedge clk);
		chk("status", 9'h008, 9'(status));
		chk("so_oe", 9'h0, 9'(so_oe));
		chk("guard", 9'h2, 9'(guard_bits));
		mst_u.xfer({16'h0, ESW_OP_STAT_RD, 8'h00}, 16, rx);
		chk("read", 9'h008, 9'(rx));
	endtask

	initial begin
		nrst = 1'b0;
		guard_n = 1'b1;
		prog_done = 1'b0;
		guard_nv = 2'h0;
		repeat (16) @(posedge clk);
		#5 nrst = 1'b1;
		repeat (6) @(posedge clk);
		t_reset();
		t_latch();
		t_status_wr();
		t_guard();
		t_abort_busy();
		t_pin();
		t_power();
		results();
	end

	initial begin
		#1ms;
		errors++;
		results();
	end
endmodule
